// ==== crcg_top.sv ====
// core start pulse source select and subsystem master clock gating
`timescale 1ns/10ps
module crcg_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register access from the control port decoder
    input  wire logic [15:0] ctl_addr,
    input  wire logic        ctl_wr,
    input  wire logic        ctl_rd,
    input  wire logic [15:0] ctl_wdata,
    output logic      [15:0] ctl_rdata_q,
    // external frame clocks, asynchronous
    input  wire logic [11:0] ser_in_frame_clk,
    input  wire logic [11:0] ser_out_frame_clk,
    input  wire logic        receiver_frame_clk,
    // core launch
    output logic             core_start_q,
    output logic      [11:0] steps_per_pass_q,
    // subsystem clock enables
    output logic             en_routing_q,
    output logic             en_ser_in_q,
    output logic             en_ser_out_q,
    output logic             en_src1_q,
    output logic             en_src2_q,
    output logic             en_core_q,
    output logic             en_receiver_q,
    output logic             en_transmitter_q,
    output logic             en_aux_adc_q
);
    logic [4:0]  rate_sel_q;
    logic [4:0]  rate_sel_d;
    logic [8:0]  gate_q;
    logic [8:0]  gate_d;
    logic [15:0] rdata_d;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic        start_d;
    logic [11:0] steps_d;
    logic [crcg_pkg::EXT_SRC-1:0] ext_rise;
    logic        wr_rate;
    logic        wr_gate;
    logic        wrap;

    function automatic logic sel_legal(input logic [4:0] s);
        sel_legal = (s <= crcg_pkg::SEL_RECEIVER);
    endfunction

    // steps per pass of the internal rate; unused codes fall to normal
    function automatic logic [11:0] steps_of(input logic [4:0] s);
        case (s)
            crcg_pkg::SEL_DOUBLE: steps_of = crcg_pkg::STEPS_DOUBLE;
            crcg_pkg::SEL_QUAD:   steps_of = crcg_pkg::STEPS_QUAD;
            default:              steps_of = crcg_pkg::STEPS_NORMAL;
        endcase
    endfunction

    crcg_frame_sync #(
        .W (crcg_pkg::EXT_SRC)
    ) u_sync (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .frame_clk_async ({receiver_frame_clk, ser_out_frame_clk,
                           ser_in_frame_clk}),
        .rise_q          (ext_rise)
    );

    // register file
    always_comb begin
        wr_rate    = ctl_wr && (ctl_addr == crcg_pkg::ADDR_RATE_SEL);
        wr_gate    = ctl_wr && (ctl_addr == crcg_pkg::ADDR_CLK_GATE);
        rate_sel_d = rate_sel_q;
        gate_d     = gate_q;
        // reserved bits are dropped; out-of-range codes leave the old one
        if (wr_rate && sel_legal(ctl_wdata[4:0])) begin
            rate_sel_d = ctl_wdata[4:0];
        end
        if (wr_gate) begin
            gate_d = ctl_wdata[8:0];
        end
        rdata_d = ctl_rdata_q;
        if (ctl_rd) begin
            if (ctl_addr == crcg_pkg::ADDR_RATE_SEL) begin
                rdata_d = {11'h000, rate_sel_q};
            end else if (ctl_addr == crcg_pkg::ADDR_CLK_GATE) begin
                rdata_d = {7'h00, gate_q};
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rate_sel_q  <= crcg_pkg::SEL_RESET;
            gate_q      <= crcg_pkg::GATE_RESET;
            ctl_rdata_q <= 16'h0000;
        end else begin
            rate_sel_q  <= rate_sel_d;
            gate_q      <= gate_d;
            ctl_rdata_q <= rdata_d;
        end
    end

    // start pulse generation
    always_comb begin
        steps_d = steps_of(rate_sel_q);
        // >= keeps the counter safe when the rate rises mid-pass
        wrap    = (cnt_q >= steps_d - 12'h001);
        cnt_d   = wrap ? 12'h000 : cnt_q + 12'h001;
        if (rate_sel_q <= crcg_pkg::SEL_QUAD) begin
            start_d = wrap;
        end else if (sel_legal(rate_sel_q)) begin
            // external sources follow the synchronised frame clock edge
            start_d = ext_rise[rate_sel_q - crcg_pkg::SEL_SER_IN0];
        end else begin
            start_d = wrap;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q            <= 12'h000;
            core_start_q     <= 1'b0;
            steps_per_pass_q <= crcg_pkg::STEPS_NORMAL;
        end else begin
            cnt_q            <= cnt_d;
            core_start_q     <= start_d;
            steps_per_pass_q <= steps_d;
        end
    end

    // gate outputs straight from the gate register bits
    always_comb begin
        en_routing_q     = gate_q[crcg_pkg::GB_ROUTING];
        en_ser_in_q      = gate_q[crcg_pkg::GB_SER_IN];
        en_ser_out_q     = gate_q[crcg_pkg::GB_SER_OUT];
        en_src1_q        = gate_q[crcg_pkg::GB_SRC1];
        en_src2_q        = gate_q[crcg_pkg::GB_SRC2];
        en_core_q        = gate_q[crcg_pkg::GB_CORE];
        en_receiver_q    = gate_q[crcg_pkg::GB_RECEIVER];
        en_transmitter_q = gate_q[crcg_pkg::GB_TRANSMITTER];
        en_aux_adc_q     = gate_q[crcg_pkg::GB_AUX_ADC];
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_rate_wr_legal;
        ctl_wr && ctl_addr == crcg_pkg::ADDR_RATE_SEL
            && ctl_wdata[4:0] <= crcg_pkg::SEL_RECEIVER;
    endsequence

    sequence s_ext_edge(int lo, int hi);
        rate_sel_q >= lo && rate_sel_q <= hi && !ctl_wr
            && ext_rise[rate_sel_q - crcg_pkg::SEL_SER_IN0];
    endsequence

    a_sel_in_range: assert property (
        rate_sel_q <= crcg_pkg::SEL_RECEIVER)
        else $error("start select holds an unused code");

    a_illegal_ignored: assert property (
        ctl_wr && ctl_addr == crcg_pkg::ADDR_RATE_SEL
            && ctl_wdata[4:0] > crcg_pkg::SEL_RECEIVER |=> $stable(rate_sel_q))
        else $error("unused select code was stored");

    a_rate_write: assert property (
        s_rate_wr_legal |=> rate_sel_q == $past(ctl_wdata[4:0])
            ##1 ctl_rdata_q == {11'h000, $past(rate_sel_q)} || !$past(ctl_rd))
        else $error("rate select write not stored");

    a_gate_write: assert property (
        ctl_wr && ctl_addr == crcg_pkg::ADDR_CLK_GATE
            |=> en_core_q == $past(ctl_wdata[5])
            && en_routing_q == $past(ctl_wdata[0])
            && en_aux_adc_q == $past(ctl_wdata[8]))
        else $error("gate write did not reach enables");

    a_gate_reset: assert property (
        @(posedge clk_sys) $fell(rst) |-> gate_q == 9'h000 && !en_core_q)
        else $error("gate bits not cleared by reset");

    a_internal_pulse: assert property (
        rate_sel_q <= crcg_pkg::SEL_QUAD && cnt_q == steps_d - 12'h001
            |=> core_start_q && cnt_q == 12'h000)
        else $error("internal start pulse missing at wrap");

    a_internal_quiet: assert property (
        rate_sel_q <= crcg_pkg::SEL_QUAD && cnt_q != 12'h000
            && $stable(rate_sel_q) |-> !core_start_q)
        else $error("internal start pulse off its pass boundary");

    a_serial_in: assert property (
        s_ext_edge(3, 14) |=> core_start_q)
        else $error("serial input frame edge not followed");

    a_serial_out: assert property (
        s_ext_edge(15, 26) |=> core_start_q)
        else $error("serial output frame edge not followed");

    a_receiver: assert property (
        rate_sel_q == crcg_pkg::SEL_RECEIVER && !ctl_wr
            && ext_rise[crcg_pkg::EXT_SRC-1] |=> core_start_q)
        else $error("receiver frame edge not followed");

    a_steps_rate: assert property (
        rate_sel_q == crcg_pkg::SEL_QUAD && $stable(rate_sel_q)
            |-> steps_per_pass_q == 12'd896)
        else $error("quad rate step count wrong");

    a_steps_double: assert property (
        rate_sel_q == crcg_pkg::SEL_DOUBLE && $stable(rate_sel_q)
            |-> steps_per_pass_q == 12'd1792)
        else $error("double rate step count wrong");

    a_gate_order: assert property (
        ctl_wr && ctl_addr == crcg_pkg::ADDR_CLK_GATE
            |=> {en_src2_q, en_src1_q, en_ser_out_q, en_ser_in_q,
                 en_routing_q} == $past(ctl_wdata[4:0]))
        else $error("lower gate bits reach the wrong enables");

    a_gate_upper: assert property (
        ctl_wr && ctl_addr == crcg_pkg::ADDR_CLK_GATE
            |=> {en_aux_adc_q, en_transmitter_q, en_receiver_q,
                 en_core_q} == $past(ctl_wdata[8:5]))
        else $error("upper gate bits reach the wrong enables");

    a_gate_read: assert property (
        ctl_rd && ctl_addr == crcg_pkg::ADDR_CLK_GATE
            |=> ctl_rdata_q == {7'h00, $past(gate_q)})
        else $error("gate register read back wrong");
endmodule

// ==== crcg_pkg.sv ====
// constants for the core rate select and subsystem clock gating block
// Notes on behaviour
// - each start pulse launches one core pass and sets the core sample rate
// - start select is bits [4:0] of rate select, reset 00000 = normal rate
// - code 00001 selects internal double rate, 00010 internal quad rate
// - codes 00011 to 01110 select serial input pair 0 to 11 frame clock
// - codes 01111 to 11010 select serial output pair 0 to 11 frame clock
// - code 11011 selects the receiver's recovered frame clock
// - core clock is 3584, 1792 or 896 times normal, double, quad rate
// - with an external frame clock selected the core follows that clock
// - a gate bit at 1 passes the master clock, at 0 stops it
// - gate bits 0 to 4: routing, serial in, serial out, converter 1, 2
// - gate bits 5 to 8: core, receiver, transmitter, auxiliary converters
// - all gate bits reset to 0, subsystems unclocked until enabled
// - core clock is a 64x normal rate reference multiplied by 56
// - both registers read and write through either control port
package crcg_pkg;
    localparam logic [15:0] ADDR_RATE_SEL   = 16'he220;
    localparam logic [15:0] ADDR_CLK_GATE   = 16'he280;
    localparam int          SEL_LSB         = 0;
    localparam int          SEL_W           = 5;
    localparam int          GATE_W          = 9;
    localparam logic [4:0]  SEL_RESET       = 5'h00;
    localparam logic [8:0]  GATE_RESET      = 9'h000;
    // start select codes
    localparam logic [4:0]  SEL_NORMAL      = 5'h00;
    localparam logic [4:0]  SEL_DOUBLE      = 5'h01;
    localparam logic [4:0]  SEL_QUAD        = 5'h02;
    localparam logic [4:0]  SEL_SER_IN0     = 5'h03;
    localparam logic [4:0]  SEL_SER_OUT0    = 5'h0f;
    localparam logic [4:0]  SEL_RECEIVER    = 5'h1b;
    localparam int          PAIRS           = 12;
    localparam int          EXT_SRC         = 2 * PAIRS + 1;
    // gate bit positions
    localparam int          GB_ROUTING      = 0;
    localparam int          GB_SER_IN       = 1;
    localparam int          GB_SER_OUT      = 2;
    localparam int          GB_SRC1         = 3;
    localparam int          GB_SRC2         = 4;
    localparam int          GB_CORE         = 5;
    localparam int          GB_RECEIVER     = 6;
    localparam int          GB_TRANSMITTER  = 7;
    localparam int          GB_AUX_ADC      = 8;
    // core clock ratios: reference 64x normal rate times 56
    localparam int          REF_MULT        = 64;
    localparam int          CORE_MULT       = 56;
    localparam int          STEP_W          = 12;
    localparam logic [11:0] STEPS_NORMAL    = 12'(REF_MULT * CORE_MULT);
    localparam logic [11:0] STEPS_DOUBLE    = 12'(REF_MULT * CORE_MULT / 2);
    localparam logic [11:0] STEPS_QUAD      = 12'(REF_MULT * CORE_MULT / 4);
endpackage

// ==== crcg_frame_sync.sv ====
// two-stage synchroniser and rising edge detector for external frame clocks
`timescale 1ns/10ps
module crcg_frame_sync #(
    parameter int W = 25
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // asynchronous frame clocks in, one-cycle rise pulses out
    input  wire logic [W-1:0] frame_clk_async,
    output logic      [W-1:0] rise_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;
    logic [W-1:0] rise_d;

    always_comb begin
        rise_d = sync_q & ~last_q;
    end

    // meta_q feeds only sync_q
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
            rise_q <= '0;
        end else begin
            meta_q <= frame_clk_async;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise_q <= rise_d;
        end
    end
endmodule

// ==== core_rate_and_clock_gating_test.sv ====
// self-checking bench for core start select and subsystem clock gating
`timescale 1ns/10ps
module core_rate_and_clock_gating_test;
    logic        clk_sys;
    logic        rst;
    logic [15:0] ctl_addr;
    logic        ctl_wr;
    logic        ctl_rd;
    logic [15:0] ctl_wdata;
    logic [15:0] ctl_rdata_q;
    logic [11:0] ser_in_frame_clk;
    logic [11:0] ser_out_frame_clk;
    logic        receiver_frame_clk;
    logic        core_start_q;
    logic [11:0] steps_per_pass_q;
    logic [8:0]  en;
    int          mismatches;
    int          comparisons;
    int          sel_m;
    int          n;
    logic [31:0] rnd;

    crcg_top dut (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .ctl_addr           (ctl_addr),
        .ctl_wr             (ctl_wr),
        .ctl_rd             (ctl_rd),
        .ctl_wdata          (ctl_wdata),
        .ctl_rdata_q        (ctl_rdata_q),
        .ser_in_frame_clk   (ser_in_frame_clk),
        .ser_out_frame_clk  (ser_out_frame_clk),
        .receiver_frame_clk (receiver_frame_clk),
        .core_start_q       (core_start_q),
        .steps_per_pass_q   (steps_per_pass_q),
        .en_routing_q       (en[0]),
        .en_ser_in_q        (en[1]),
        .en_ser_out_q       (en[2]),
        .en_src1_q          (en[3]),
        .en_src2_q          (en[4]),
        .en_core_q          (en[5]),
        .en_receiver_q      (en[6]),
        .en_transmitter_q   (en[7]),
        .en_aux_adc_q       (en[8])
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        ctl_addr  = a;
        ctl_wdata = d;
        ctl_wr    = 1'b1;
        @(negedge clk_sys);
        ctl_wr = 1'b0;
        // only legal codes land in the model; others leave it unchanged
        if (a == crcg_pkg::ADDR_RATE_SEL && d[4:0] <= 5'h1b) begin
            sel_m = int'(d[4:0]);
        end
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        ctl_addr = a;
        ctl_rd   = 1'b1;
        @(negedge clk_sys);
        ctl_rd = 1'b0;
        d      = ctl_rdata_q;
    endtask

    // bounded wait for the next start pulse, counting falling edges
    task automatic wait_start(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_sys);
            cnt++;
        end while (core_start_q !== 1'b1 && cnt < 4000);
        if (cnt >= 4000) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic quiet();
        repeat (8) begin
            @(negedge clk_sys);
            check({15'h0, core_start_q}, 16'h0);
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        logic [15:0] d;
        logic [15:0] g;
        rst         = 1'b1;
        ctl_addr    = 16'h0;
        ctl_wr      = 1'b0;
        ctl_rd      = 1'b0;
        ctl_wdata   = 16'h0;
        {receiver_frame_clk, ser_out_frame_clk, ser_in_frame_clk} = 25'h0;
        mismatches  = 0;
        comparisons = 0;
        sel_m       = 0;
        rnd         = 32'h1886d9c0;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        rd(crcg_pkg::ADDR_RATE_SEL, d);
        check(d, 16'h0);
        rd(crcg_pkg::ADDR_CLK_GATE, d);
        check(d, 16'h0);
        check({7'h0, en}, 16'h0);
        check({4'h0, steps_per_pass_q}, 16'he00);
        // the gate register is the first one written after reset
        wr(crcg_pkg::ADDR_CLK_GATE, 16'h01ff);
        check({7'h0, en}, 16'h01ff);
        $display("test reset done");
        // first gap after a change may be cut short by the wrap, so skip it
        for (int s = 2; s >= 0; s--) begin
            wr(crcg_pkg::ADDR_RATE_SEL, 16'(s));
            wait_start(n);
            wait_start(n);
            check(16'(n), 16'he00 >> s);
            check({4'h0, steps_per_pass_q}, 16'he00 >> s);
        end
        $display("test internal rates done");
        wr(crcg_pkg::ADDR_RATE_SEL, 16'hffe2);
        for (int c = 28; c < 32; c++) begin
            wr(crcg_pkg::ADDR_RATE_SEL, 16'(c));
            rd(crcg_pkg::ADDR_RATE_SEL, d);
            check(d, 16'(sel_m));
        end
        check({4'h0, steps_per_pass_q}, 16'h380);
        $display("test reserved codes done");
        for (int i = 0; i < 17; i++) begin
            rnd = xs(rnd);
            g   = (i < 9) ? (16'h1 << i) : rnd[15:0];
            wr(crcg_pkg::ADDR_CLK_GATE, g);
            check({7'h0, en}, {7'h0, g[8:0]});
            rd(crcg_pkg::ADDR_CLK_GATE, d);
            check(d, {7'h0, g[8:0]});
        end
        wr(16'he224, 16'hffff);
        rd(16'he224, d);
        check(d, 16'h0);
        check({7'h0, en}, {7'h0, g[8:0]});
        $display("test clock gate done");
        for (int c = 3; c < 28; c++) begin
            wr(crcg_pkg::ADDR_RATE_SEL, 16'(c));
            @(negedge clk_sys);
            {receiver_frame_clk, ser_out_frame_clk, ser_in_frame_clk} =
                ~(25'h1 << (c - 3));
            quiet();
            {receiver_frame_clk, ser_out_frame_clk, ser_in_frame_clk} =
                25'h1ffffff;
            wait_start(n);
            check(16'(n >= 4 && n <= 5), 16'h1);
            check({4'h0, steps_per_pass_q}, 16'he00);
            {receiver_frame_clk, ser_out_frame_clk, ser_in_frame_clk} = 25'h0;
            quiet();
        end
        $display("test external sources done");
        wr(crcg_pkg::ADDR_RATE_SEL, 16'h0);
        conclude();
    end
endmodule
